// file: timer_ch0_capture_compare_status.sv
// Channel 0 register D capture/compare, status flags, interrupts and AXI4-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
`include "timer_ch0_defines.svh"
module timer_ch0_capture_compare_status (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [3:0]              s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [3:0]              s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  input  wire logic [15:0]             channel_counter,
  input  wire logic [15:0]             general_register_a,
  input  wire logic [15:0]             general_register_b,
  input  wire logic [15:0]             general_register_c,
  input  wire logic                    compare_mode_a,
  input  wire logic                    compare_mode_b,
  input  wire logic                    compare_mode_c,
  input  wire logic                    capture_a,
  input  wire logic                    capture_b,
  input  wire logic                    capture_c,
  input  wire logic                    buffer_mode_a,
  input  wire logic                    buffer_mode_b,
  input  wire logic                    channel1_count,
  input  wire logic [2:0]              channel1_prescaler_select,
  input  wire logic                    xfer_activate_a,
  input  wire logic                    xfer_activate_b,
  input  wire logic                    xfer_activate_c,
  input  wire logic                    xfer_activate_d,
  input  wire logic                    transfer_disable_select,
  input  wire logic                    dma_activate_a,
  input  wire logic                    dma_acknowledge_select,
  input  wire logic                    capture_compare_pin_d_in,
  output logic                         capture_compare_pin_d_out,
  output logic                         capture_compare_pin_d_oe,
  output logic                         irq_a,
  output logic                         irq_b,
  output logic                         irq_c,
  output logic                         irq_d,
  output logic                         irq_overflow,
  output logic                         irq,
  output logic                         ad_start_request
);
  import timer_ch0_pkg::*;

  logic [3:0]  io_control_d;
  logic        ad_enable;
  flags_t      status;
  flags_t      armed;
  flags_t      irq_enable;
  logic [15:0] general_register_d;
  logic [15:0] counter_prev;
  logic        pin_meta;
  logic        pin_sync;
  logic        pin_prev;
  logic        pin_level;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        ad_request;

  logic [3:0]  next_io_control_d;
  logic        next_ad_enable;
  flags_t      next_status;
  flags_t      next_armed;
  flags_t      next_irq_enable;
  logic [15:0] next_general_register_d;
  logic        next_pin_level;
  logic        next_aw_held;
  logic        next_w_held;
  logic [3:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_ad_request;

  io_mode_t    mode_d;
  logic        counter_moved;
  logic        match_d;
  logic        capture_d;
  logic        rise;
  logic        fall;
  logic        do_write;
  logic        do_read;
  logic        wr_status;
  flags_t      set_event;
  flags_t      hw_clear;
  flags_t      sw_clear;
  logic [31:0] read_value;

  // The pin is asynchronous; only the second and third stages feed the edge detector.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= capture_compare_pin_d_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;
  assign counter_moved = channel_counter != counter_prev;

  always_comb begin
    if (buffer_mode_b) begin
      mode_d = MODE_BUFFER;
    end else if (!io_control_d[`IO_CAPTURE_BIT]) begin
      mode_d = MODE_COMPARE;
    end else if (io_control_d[`IO_LEVEL_BIT]) begin
      mode_d = MODE_CAPTURE_CH1;
    end else begin
      mode_d = MODE_CAPTURE_PIN;
    end
  end

  always_comb begin
    match_d   = 1'b0;
    capture_d = 1'b0;
    unique case (mode_d)
      MODE_COMPARE: begin
        match_d = counter_moved && (channel_counter == general_register_d);
      end
      MODE_CAPTURE_PIN: begin
        unique case (io_control_d[1:0])
          2'h0:    capture_d = rise;
          2'h1:    capture_d = fall;
          default: capture_d = rise | fall;
        endcase
      end
      MODE_CAPTURE_CH1: begin
        capture_d = channel1_count && (channel1_prescaler_select != `PRESCALER_UNDIV);
      end
      MODE_BUFFER: begin
        match_d   = 1'b0;
      end
    endcase
  end

  always_comb begin
    set_event = '0;
    set_event[`FLAG_A] = compare_mode_a ? (counter_moved && channel_counter == general_register_a)
                                        : capture_a;
    set_event[`FLAG_B] = compare_mode_b ? (counter_moved && channel_counter == general_register_b)
                                        : capture_b;
    set_event[`FLAG_C] = buffer_mode_a ? 1'b0
                       : compare_mode_c ? (counter_moved && channel_counter == general_register_c)
                       : capture_c;
    set_event[`FLAG_D] = match_d | capture_d;
    set_event[`FLAG_OVF] = (counter_prev == `COUNTER_MAX) && (channel_counter == `COUNTER_ZERO);
    hw_clear = '0;
    hw_clear[`FLAG_A] = (xfer_activate_a && !transfer_disable_select)
                      || (dma_activate_a && dma_acknowledge_select);
    hw_clear[`FLAG_B] = xfer_activate_b && !transfer_disable_select;
    hw_clear[`FLAG_C] = xfer_activate_c && !transfer_disable_select;
    hw_clear[`FLAG_D] = xfer_activate_d && !transfer_disable_select;
  end

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign do_write  = aw_held && w_held && !bvalid;
  assign do_read   = s_axi_arvalid && !rvalid;
  assign wr_status = do_write && aw_addr == `OFS_STATUS && w_strb[0];

  // Only flags seen as one by a read may be cleared by the following zero write.
  assign sw_clear = wr_status ? (armed & ~w_data[4:0]) : '0;

  always_comb begin
    unique case (s_axi_araddr)
      `OFS_IO_CONTROL_D:  read_value = {24'h0, ad_enable, 3'h0, io_control_d};
      `OFS_STATUS:        read_value = {24'h0, `STATUS_FIXED_ONES | {3'h0, status}};
      `OFS_IRQ_ENABLE:    read_value = {27'h0, irq_enable};
      `OFS_GENERAL_REG_D: read_value = {16'h0, general_register_d};
      default:            read_value = 32'h0;
    endcase
  end

  always_comb begin
    next_io_control_d       = io_control_d;
    next_ad_enable          = ad_enable;
    next_irq_enable         = irq_enable;
    next_general_register_d = general_register_d;
    next_pin_level          = pin_level;
    next_aw_held            = aw_held;
    next_w_held             = w_held;
    next_aw_addr            = aw_addr;
    next_w_data             = w_data;
    next_w_strb             = w_strb;
    next_bvalid             = bvalid;
    next_bresp              = bresp;
    next_rvalid             = rvalid;
    next_rdata              = rdata;
    next_rresp              = rresp;
    // A flag event in the clearing cycle wins over every clear.
    next_status = (status & ~hw_clear & ~sw_clear) | set_event;
    next_armed  = armed & ~sw_clear & ~hw_clear;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `RESP_OKAY;
      unique case (aw_addr)
        `OFS_IO_CONTROL_D: begin
          if (w_strb[0]) begin
            next_io_control_d = w_data[3:0];
            next_ad_enable    = w_data[`CTL_AD_ENABLE_BIT];
            next_pin_level    = w_data[`IO_LEVEL_BIT];
          end
        end
        `OFS_STATUS: begin
          next_bresp = `RESP_OKAY;
        end
        `OFS_IRQ_ENABLE: begin
          if (w_strb[0]) begin
            next_irq_enable = w_data[4:0];
          end
        end
        `OFS_GENERAL_REG_D: begin
          if (w_strb[0]) begin
            next_general_register_d[7:0] = w_data[7:0];
          end
          if (w_strb[1]) begin
            next_general_register_d[15:8] = w_data[15:8];
          end
        end
        default: begin
          next_bresp = `RESP_DECERR;
        end
      endcase
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (capture_d) begin
      next_general_register_d = channel_counter;
    end
    if (match_d) begin
      unique case (io_control_d[1:0])
        2'h0:    next_pin_level = pin_level;
        2'h1:    next_pin_level = 1'b0;
        2'h2:    next_pin_level = 1'b1;
        default: next_pin_level = ~pin_level;
      endcase
    end
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rdata  = read_value;
      next_rresp  = (s_axi_araddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_DECERR;
      if (s_axi_araddr == `OFS_STATUS) begin
        next_armed = (armed & ~sw_clear & ~hw_clear) | status;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // Conversion start follows a register A event, gated by software.
    next_ad_request = ad_enable && set_event[`FLAG_A];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_control_d       <= `RESET_IO_CONTROL;
      ad_enable          <= 1'b0;
      status             <= `RESET_FLAGS;
      armed              <= `RESET_FLAGS;
      irq_enable         <= `RESET_FLAGS;
      general_register_d <= `RESET_GENERAL_D;
      counter_prev       <= 16'h0000;
      pin_level          <= 1'b0;
      aw_held            <= 1'b0;
      w_held             <= 1'b0;
      aw_addr            <= 4'h0;
      w_data             <= 32'h0;
      w_strb             <= 4'h0;
      bvalid             <= 1'b0;
      bresp              <= `RESP_OKAY;
      rvalid             <= 1'b0;
      rdata              <= 32'h0;
      rresp              <= `RESP_OKAY;
      ad_request         <= 1'b0;
    end else begin
      io_control_d       <= next_io_control_d;
      ad_enable          <= next_ad_enable;
      status             <= next_status;
      armed              <= next_armed;
      irq_enable         <= next_irq_enable;
      general_register_d <= next_general_register_d;
      counter_prev       <= channel_counter;
      pin_level          <= next_pin_level;
      aw_held            <= next_aw_held;
      w_held             <= next_w_held;
      aw_addr            <= next_aw_addr;
      w_data             <= next_w_data;
      w_strb             <= next_w_strb;
      bvalid             <= next_bvalid;
      bresp              <= next_bresp;
      rvalid             <= next_rvalid;
      rdata              <= next_rdata;
      rresp              <= next_rresp;
      ad_request         <= next_ad_request;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rdata;
  assign s_axi_rresp  = rresp;

  // The pin is driven only in compare mode with an action selected; buffer mode releases it.
  assign capture_compare_pin_d_out = pin_level;
  assign capture_compare_pin_d_oe  = (mode_d == MODE_COMPARE) && (io_control_d[1:0] != 2'h0);
  assign ad_start_request          = ad_request;

  assign irq_a        = status[`FLAG_A] & irq_enable[`FLAG_A];
  assign irq_b        = status[`FLAG_B] & irq_enable[`FLAG_B];
  assign irq_c        = status[`FLAG_C] & irq_enable[`FLAG_C];
  assign irq_d        = status[`FLAG_D] & irq_enable[`FLAG_D];
  assign irq_overflow = status[`FLAG_OVF] & irq_enable[`FLAG_OVF];
  assign irq          = |(status & irq_enable);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_write_taken;
    do_write;
  endsequence

  sequence seq_answer_given;
    ##1 s_axi_bvalid;
  endsequence

  chk_write_answer: assert property (seq_write_taken |-> seq_answer_given)
    else $error("Write response missing one cycle after the write.");

  chk_initial_level: assert property (do_write && aw_addr == `OFS_IO_CONTROL_D && w_strb[0] && !w_data[3]
                                      |=> capture_compare_pin_d_out == $past(w_data[2]))
    else $error("Initial compare level does not follow bit 2.");

  chk_toggle_action: assert property (match_d && io_control_d[1:0] == 2'h3 && !do_write
                                      |=> capture_compare_pin_d_out != $past(capture_compare_pin_d_out))
    else $error("Toggle action did not invert the pin.");

  chk_pin_capture: assert property (mode_d == MODE_CAPTURE_PIN && io_control_d[1:0] == 2'h0 && rise
                                    |=> general_register_d == $past(channel_counter) && status[`FLAG_D])
    else $error("Rising edge capture missing.");

  chk_ch1_capture: assert property (mode_d == MODE_CAPTURE_CH1 && channel1_count
                                    && channel1_prescaler_select != 3'h0 |-> capture_d)
    else $error("Channel 1 count did not capture.");

  chk_undivided_none: assert property (channel1_prescaler_select == 3'h0 && mode_d == MODE_CAPTURE_CH1
                                       |-> !capture_d)
    else $error("Capture with undivided channel 1 clock.");

  chk_buffer_quiet: assert property (buffer_mode_b |-> !set_event[`FLAG_D] && !capture_compare_pin_d_oe)
    else $error("Register D active while in buffer mode.");

  chk_buffer_c_quiet: assert property (buffer_mode_a |=> !$rose(status[`FLAG_C]))
    else $error("Flag C set while register C is a buffer.");

  chk_ad_gate: assert property (ad_start_request |-> $past(ad_enable) && $past(set_event[`FLAG_A]))
    else $error("Conversion start without enable.");

  chk_fixed_ones: assert property (s_axi_rvalid && $past(do_read && s_axi_araddr == `OFS_STATUS)
                                   |-> s_axi_rdata[7:6] == 2'h3)
    else $error("Status bits 7 and 6 did not read as one.");

  chk_no_set_by_write: assert property (!status[`FLAG_A] && !set_event[`FLAG_A] |=> !status[`FLAG_A])
    else $error("Flag A set without an event.");

  chk_set_wins: assert property (set_event[`FLAG_B] |=> status[`FLAG_B])
    else $error("Flag B event lost.");

  chk_compare_a: assert property (compare_mode_a && counter_moved && channel_counter == general_register_a
                                  |=> status[`FLAG_A])
    else $error("Compare match did not set flag A.");

  chk_capture_a: assert property (!compare_mode_a && capture_a |=> status[`FLAG_A])
    else $error("Capture did not set flag A.");

  chk_xfer_clear_a: assert property (xfer_activate_a && !transfer_disable_select && !set_event[`FLAG_A]
                                    |=> !status[`FLAG_A])
    else $error("Transfer controller did not clear flag A.");

  chk_dma_clear_a: assert property (dma_activate_a && dma_acknowledge_select && !set_event[`FLAG_A]
                                    |=> !status[`FLAG_A])
    else $error("DMA did not clear flag A.");

  chk_xfer_clear_c: assert property (xfer_activate_c && !transfer_disable_select && !set_event[`FLAG_C]
                                    |=> !status[`FLAG_C])
    else $error("Transfer controller did not clear flag C.");

  chk_overflow_set: assert property ($past(channel_counter) == 16'hFFFF && channel_counter == 16'h0000
                                     |=> status[`FLAG_OVF])
    else $error("Counter wrap did not set the overflow flag.");

  chk_irq_level: assert property (status[`FLAG_D] && irq_enable[`FLAG_D] |-> irq && irq_d)
    else $error("Enabled flag D raised no interrupt.");

endmodule : timer_ch0_capture_compare_status
`default_nettype wire

// file: timer_ch0_defines.svh
// Offsets, field positions, reset values and response codes of the channel 0 status block.
`ifndef TIMER_CH0_DEFINES_SVH
`define TIMER_CH0_DEFINES_SVH

`define OFS_IO_CONTROL_D   4'h0
`define OFS_STATUS         4'h4
`define OFS_IRQ_ENABLE     4'h8
`define OFS_GENERAL_REG_D  4'hC

`define CTL_AD_ENABLE_BIT  7
`define IO_CAPTURE_BIT     3
`define IO_LEVEL_BIT       2

`define FLAG_A             0
`define FLAG_B             1
`define FLAG_C             2
`define FLAG_D             3
`define FLAG_OVF           4
`define FLAG_COUNT         5

`define STATUS_FIXED_ONES  8'hC0
`define RESET_IO_CONTROL   4'h0
`define RESET_FLAGS        5'h00
`define RESET_GENERAL_D    16'hFFFF
`define COUNTER_MAX        16'hFFFF
`define COUNTER_ZERO       16'h0000
`define PRESCALER_UNDIV    3'h0

`define RESP_OKAY          2'h0
`define RESP_DECERR        2'h3

`endif

// file: timer_ch0_pkg.sv
// Types shared by the channel 0 capture/compare and status block.
`default_nettype none
package timer_ch0_pkg;

  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_CAPTURE_PIN,
    MODE_CAPTURE_CH1,
    MODE_BUFFER
  } io_mode_t;

  typedef logic [4:0] flags_t;

endpackage : timer_ch0_pkg
`default_nettype wire

// file: counter_model.sv
// Partner model of the channel 0 counter that feeds the status block.
`timescale 1ns/10ps
`default_nettype none
module counter_model (
  input  wire logic        aclk,
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  input  wire logic        run,
  output logic      [15:0] count
);
  // The counter only moves when told to, so each compare scenario sees a known sweep of values.
  always_ff @(posedge aclk) begin
    if (load) count <= load_value;
    else if (run) count <= count + 16'h0001;
  end
endmodule : counter_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the channel 0 capture/compare status block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, load, run;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] channel_counter, general_register_a, general_register_b, general_register_c, load_value;
  logic        compare_mode_a, compare_mode_b, compare_mode_c, capture_a, capture_b, capture_c;
  logic        buffer_mode_a, buffer_mode_b, channel1_count, transfer_disable_select, dma_activate_a;
  logic        dma_acknowledge_select, xfer_activate_b, capture_compare_pin_d_in, capture_compare_pin_d_out;
  logic        xfer_activate_a, xfer_activate_c, xfer_activate_d;
  logic        capture_compare_pin_d_oe, irq_a, irq_b, irq_c, irq_d, irq_overflow, irq, ad_start_request;
  logic [2:0]  channel1_prescaler_select;
  int          n_mismatch = 0, n_compared = 0, n_ad = 0;
  timer_ch0_capture_compare_status i_timer_ch0_capture_compare_status (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .channel_counter, .general_register_a, .general_register_b, .general_register_c,
    .compare_mode_a, .compare_mode_b, .compare_mode_c, .capture_a, .capture_b, .capture_c, .buffer_mode_a,
    .buffer_mode_b, .channel1_count, .channel1_prescaler_select, .xfer_activate_a, .xfer_activate_b,
    .xfer_activate_c, .xfer_activate_d, .transfer_disable_select, .dma_activate_a,
    .dma_acknowledge_select, .capture_compare_pin_d_in, .capture_compare_pin_d_out, .capture_compare_pin_d_oe,
    .irq_a, .irq_b, .irq_c, .irq_d, .irq_overflow, .irq, .ad_start_request);
  counter_model i_counter_model (.aclk, .load, .load_value, .run, .count(channel_counter));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (ad_start_request === 1'b1) n_ad <= n_ad + 1;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rdr
  task automatic st(input logic [7:0] e);
    rdr(4'h4);
    `CHK("status", e, rd[7:0])
  endtask : st
  // A flag is only cleared by a write after it has been read as one, so the read comes first.
  task automatic clr(input int b);
    rdr(4'h4);
    wr(4'h4, 32'h000000FF ^ (32'h00000001 << b));
  endtask : clr
  task automatic ev(input logic [5:0] m);
    @(posedge aclk);
    {dma_activate_a, xfer_activate_b, channel1_count, capture_c, capture_b, capture_a} <= m;
    @(posedge aclk);
    {dma_activate_a, xfer_activate_b, channel1_count, capture_c, capture_b, capture_a} <= 6'h00;
    repeat (3) @(posedge aclk);
  endtask : ev
  task automatic xfer(input logic [2:0] m);
    @(posedge aclk);
    {xfer_activate_d, xfer_activate_c, xfer_activate_a} <= m;
    @(posedge aclk);
    {xfer_activate_d, xfer_activate_c, xfer_activate_a} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask : xfer
  task automatic sweep(input logic [15:0] v, input int n);
    @(posedge aclk);
    load <= 1'b1;
    load_value <= v;
    @(posedge aclk);
    {load, run} <= 2'h1;
    repeat (n) @(posedge aclk);
    run <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : sweep
  task automatic t_reset;
    st(8'hC0);
    rdr(4'h2);
    `CHK("rresp", 2'h3, rsp)
    wr(4'h2, 32'h00000000);
    `CHK("bresp", 2'h3, rsp)
    `CHK("irq", 1'b0, irq)
    $display("done reset");
  endtask : t_reset
  task automatic t_flag_a;
    wr(4'h0, 32'h00000080);
    wr(4'h8, 32'h00000001);
    sweep(16'h0038, 12);
    wr(4'h4, 32'h00000000);
    st(8'hC1);
    `CHK("irq_a", 1'b1, irq_a)
    `CHK("ad_count", 1, n_ad)
    wr(4'h4, 32'h000000FF);
    st(8'hC1);
    clr(0);
    st(8'hC0);
    `CHK("irq", 1'b0, irq)
    wr(4'h0, 32'h00000000);
    sweep(16'h0038, 12);
    `CHK("ad_count", 1, n_ad)
    clr(0);
    $display("done flag a");
  endtask : t_flag_a
  task automatic t_pin;
    wr(4'hC, 32'h00000020);
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, 32'(c));
      `CHK("oe", c[1:0] != 2'h0, capture_compare_pin_d_oe)
      if (c[1:0] != 2'h0) `CHK("pin", c[2], capture_compare_pin_d_out)
      sweep(16'h0018, 12);
      if (c[1:0] != 2'h0) `CHK("pin", c[1:0] == 2'h3 ? ~c[2] : c[1], capture_compare_pin_d_out)
    end
    st(8'hC8);
    clr(3);
    $display("done pin");
  endtask : t_pin
  task automatic t_overflow;
    sweep(16'hFFFC, 8);
    st(8'hD0);
    wr(4'h8, 32'h00000010);
    `CHK("irq_overflow", 1'b1, irq_overflow)
    clr(4);
    $display("done overflow");
  endtask : t_overflow
  task automatic t_capture;
    wr(4'h0, 32'h0000000C);
    sweep(16'h0100, 2);
    ev(6'h08);
    st(8'hC0);
    channel1_prescaler_select <= 3'h1;
    ev(6'h08);
    st(8'hC8);
    rdr(4'hC);
    `CHK("reg_d", 16'h0102, rd[15:0])
    clr(3);
    wr(4'h0, 32'h00000008);
    capture_compare_pin_d_in <= 1'b1;
    repeat (8) @(posedge aclk);
    st(8'hC8);
    clr(3);
    capture_compare_pin_d_in <= 1'b0;
    repeat (8) @(posedge aclk);
    st(8'hC0);
    buffer_mode_b <= 1'b1;
    wr(4'h0, 32'h0000000D);
    ev(6'h08);
    st(8'hC0);
    wr(4'h0, 32'h00000001);
    sweep(16'h0100, 4);
    st(8'hC0);
    `CHK("oe", 1'b0, capture_compare_pin_d_oe)
    buffer_mode_b <= 1'b0;
    $display("done capture");
  endtask : t_capture
  task automatic t_hw_clear;
    sweep(16'h0048, 12);
    st(8'hC2);
    clr(1);
    sweep(16'h005C, 8);
    st(8'hC4);
    clr(2);
    {compare_mode_a, compare_mode_b, compare_mode_c} <= 3'h0;
    ev(6'h01);
    st(8'hC1);
    ev(6'h20);
    st(8'hC1);
    dma_acknowledge_select <= 1'b1;
    ev(6'h20);
    st(8'hC0);
    ev(6'h02);
    transfer_disable_select <= 1'b1;
    ev(6'h10);
    st(8'hC2);
    transfer_disable_select <= 1'b0;
    ev(6'h10);
    st(8'hC0);
    buffer_mode_a <= 1'b1;
    ev(6'h04);
    st(8'hC0);
    buffer_mode_a <= 1'b0;
    wr(4'h0, 32'h0000000C);
    wr(4'h8, 32'h0000000F);
    ev(6'h0F);
    st(8'hCF);
    `CHK("irq_bcd", 3'h7, {irq_b, irq_c, irq_d})
    xfer(3'h7);
    st(8'hC2);
    `CHK("irq_acd", 3'h0, {irq_a, irq_c, irq_d})
    $display("done hardware clear");
  endtask : t_hw_clear
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // The whole sequence needs well under a thousand cycles; the limit leaves ample room.
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, run} = '0;
    {capture_a, capture_b, capture_c, buffer_mode_a, buffer_mode_b, channel1_count, xfer_activate_b} = '0;
    {xfer_activate_a, xfer_activate_c, xfer_activate_d} = '0;
    {transfer_disable_select, dma_activate_a, dma_acknowledge_select, capture_compare_pin_d_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, load_value, channel1_prescaler_select} = '0;
    {compare_mode_a, compare_mode_b, compare_mode_c, load} = 4'hF;
    s_axi_wstrb = 4'hF;
    general_register_a = 16'h0040;
    general_register_b = 16'h0050;
    general_register_c = 16'h0060;
    repeat (5) @(posedge aclk);
    {aresetn, load} <= 2'h2;
    t_reset();
    t_flag_a();
    t_pin();
    t_overflow();
    t_capture();
    t_hw_clear();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
